// file: common/pbr_params.svh
`ifndef PBR_PARAMS_SVH
`define PBR_PARAMS_SVH

// register byte offsets
`define PBR_ADR_CTRL     4'h0
`define PBR_ADR_STATUS   4'h4
`define PBR_ADR_IRQ_ST   4'h8
`define PBR_ADR_IRQ_MASK 4'hc

// control layout, response bit of bus b sits at PBR_C_RESP + b
`define PBR_CTRL_W   4
`define PBR_CTRL_RST 4'h0
`define PBR_C_RESP   0
`define PBR_C_SERREN 2
`define PBR_C_PWDIS  3

// status layout: detected 1:0, data parity detected 3:2, signaled serr 4
`define PBR_ST_W     5
`define PBR_ST_RST   5'h00
`define PBR_ST_DET   0
`define PBR_ST_DPD   2
`define PBR_ST_SERR  4

// perr asserts this many cycles after the data transfer
`define PBR_PERR_DLY 2

`endif

// file: common/pbr_pkg.sv
package pbr_pkg;

	typedef enum logic [1:0] {
		PBR_READ,
		PBR_POSTED,
		PBR_DELAYED
	} pbr_kind_t;

	// data phase in which the bridge takes data on a bus
	typedef struct packed {
		logic        valid;
		pbr_kind_t   kind;
		logic [31:0] data;
		logic [3:0]  be;
		logic        par;
	} pbr_phase_t;

	// data phase handed to the master of the opposite bus
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
		logic [3:0]  be;
		logic        par;
		logic        fwd;
	} pbr_fwd_t;

	// write data phase delivered as master, with the target's perr
	typedef struct packed {
		logic valid;
		logic posted;
		logic perr;
		logic fwd;
	} pbr_report_t;

endpackage

// file: src/pbr_par_fwd.sv
`timescale 1ns/100ps
`default_nettype none

module pbr_par_fwd
	import pbr_pkg::*;
(
	// system
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// incoming phase
	input  wire pbr_phase_t phase_i,
	output logic            err_o,
	// forwarded phase
	output pbr_fwd_t        fwd_o
);

	wire logic bad;

	// even parity over data, byte enables and par
	assign bad   = ^{phase_i.data, phase_i.be, phase_i.par};
	assign err_o = phase_i.valid & bad;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fwd_o <= '0;
		else
		begin
			fwd_o.valid <= phase_i.valid;
			fwd_o.data  <= phase_i.data;
			fwd_o.be    <= phase_i.be;
			fwd_o.par   <= (^{phase_i.data, phase_i.be}) ^ err_o;
			fwd_o.fwd   <= err_o;
		end
	end

endmodule

`default_nettype wire

// file: src/pbr_perr_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbr_params.svh"

module pbr_perr_gen #(
	parameter int DLY = `PBR_PERR_DLY
) (
	// system
	input  wire logic clk_i,
	input  wire logic rst_i,
	// request at the data transfer
	input  wire logic req_i,
	// perr pin
	output logic      perr_n_o,
	output logic      perr_oe_o
);

	logic [DLY-1:0] sh;
	logic           hold;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sh   <= '0;
			hold <= 1'b0;
		end
		else
		begin
			sh   <= {sh[DLY-2:0], req_i};
			hold <= sh[DLY-1];
		end
	end

	// drive low, then one cycle high before release
	assign perr_n_o  = ~sh[DLY-1];
	assign perr_oe_o = sh[DLY-1] | hold;

endmodule

`default_nettype wire

// file: src/pbr_bridge_perr.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbr_params.svh"

// Operation
// - primary write error drives primary perr after two
// - primary posted error sets primary detected bit
// - bad primary parity reproduced onto secondary bus
// - secondary write error drives secondary perr after two
// - secondary posted error sets secondary detected bit
// - bad secondary parity reproduced onto primary bus
// - secondary target perr sets secondary parity detected
// - downstream target perr raises serr when all enabled, except posted writes while PWDIS is set
// - primary target perr sets primary parity detected
// - upstream target perr raises serr when all enabled
// - never serr for parity the bridge forwarded
// - primary detected bit only for primary-bus errors
// - secondary detected bit only for secondary-bus errors
module pbr_bridge_perr
	import pbr_pkg::*;
#(
	parameter int ADR_W = 4
) (
	// system
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// wishbone slave
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [ADR_W-1:0] adr_i,
	input  wire logic [31:0]      dat_i,
	input  wire logic [3:0]       sel_i,
	output logic      [31:0]      dat_o,
	output logic                  ack_o,
	// primary bus
	input  wire pbr_phase_t       p_tgt_i,
	input  wire pbr_report_t      p_rep_i,
	output pbr_fwd_t              p_fwd_o,
	output logic                  p_perr_n_o,
	output logic                  p_perr_oe_o,
	output logic                  p_serr_n_o,
	output logic                  p_serr_oe_o,
	// secondary bus
	input  wire pbr_phase_t       s_tgt_i,
	input  wire pbr_report_t      s_rep_i,
	output pbr_fwd_t              s_fwd_o,
	output logic                  s_perr_n_o,
	output logic                  s_perr_oe_o,
	// interrupt
	output logic                  irq_o
);

	// index 0 is the primary bus, index 1 the secondary bus
	pbr_phase_t  tgt      [2];
	pbr_report_t rep      [2];
	pbr_fwd_t    fwd      [2];
	logic [1:0]  err;
	logic [1:0]  perr_req;
	logic [1:0]  perr_n;
	logic [1:0]  perr_oe;
	logic [1:0]  rep_dpd;
	logic [1:0]  rep_serr;

	logic [`PBR_CTRL_W-1:0] ctrl;
	logic [`PBR_ST_W-1:0]   status;
	logic [`PBR_ST_W-1:0]   irq_st;
	logic [`PBR_ST_W-1:0]   irq_mask;
	logic                   serr;

	assign tgt[0] = p_tgt_i;
	assign tgt[1] = s_tgt_i;
	assign rep[0] = p_rep_i;
	assign rep[1] = s_rep_i;

	wire logic both_resp;
	assign both_resp = ctrl[`PBR_C_RESP] & ctrl[`PBR_C_RESP + 1];

	for (genvar b = 0; b < 2; b++)
	begin : g_bus
		pbr_par_fwd u_fwd (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.phase_i (tgt[b]),
			.err_o   (err[b]),
			.fwd_o   (fwd[b])
		);

		assign perr_req[b] = err[b] & ctrl[`PBR_C_RESP + b];

		pbr_perr_gen #(
			.DLY (`PBR_PERR_DLY)
		) u_perr (
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.req_i     (perr_req[b]),
			.perr_n_o  (perr_n[b]),
			.perr_oe_o (perr_oe[b])
		);

		assign rep_dpd[b] = rep[b].valid & rep[b].perr
			& ctrl[`PBR_C_RESP + b];

		assign rep_serr[b] = rep[b].valid & rep[b].perr & ~rep[b].fwd
			& ctrl[`PBR_C_SERREN] & both_resp
			& ~((b == 1) && rep[b].posted && ctrl[`PBR_C_PWDIS]);
	end

	assign s_fwd_o = fwd[0];
	assign p_fwd_o = fwd[1];

	assign p_perr_n_o  = perr_n[0];
	assign p_perr_oe_o = perr_oe[0];
	assign s_perr_n_o  = perr_n[1];
	assign s_perr_oe_o = perr_oe[1];

	// serr is open drain: only the enable moves
	assign p_serr_n_o  = 1'b0;
	assign p_serr_oe_o = serr;

	// events in status layout: serr, dpd[1:0], det[1:0]
	wire logic [`PBR_ST_W-1:0] ev;
	assign ev = {|rep_serr, rep_dpd, err};

	// bus decode
	wire logic wb_hit;
	wire logic wb_fire;
	wire logic wb_wr;
	wire logic wb_rd;
	wire logic sel_ctrl;
	wire logic sel_st;
	wire logic sel_irq;
	wire logic sel_mask;
	wire logic [31:0] rd_data;

	assign wb_hit   = cyc_i & stb_i;
	assign wb_fire  = wb_hit & ack_o;
	assign wb_wr    = wb_fire & we_i & sel_i[0];
	assign wb_rd    = wb_fire & ~we_i;
	assign sel_ctrl = adr_i == ADR_W'(`PBR_ADR_CTRL);
	assign sel_st   = adr_i == ADR_W'(`PBR_ADR_STATUS);
	assign sel_irq  = adr_i == ADR_W'(`PBR_ADR_IRQ_ST);
	assign sel_mask = adr_i == ADR_W'(`PBR_ADR_IRQ_MASK);

	assign rd_data = sel_ctrl ? {{(32-`PBR_CTRL_W){1'b0}}, ctrl}
		: sel_st   ? {{(32-`PBR_ST_W){1'b0}}, status}
		: sel_irq  ? {{(32-`PBR_ST_W){1'b0}}, irq_st}
		: sel_mask ? {{(32-`PBR_ST_W){1'b0}}, irq_mask}
		: 32'h0000_0000;

	// next values: a set in the clearing cycle wins
	wire logic [`PBR_ST_W-1:0] st_clr;
	wire logic [`PBR_ST_W-1:0] irq_clr;
	wire logic [`PBR_ST_W-1:0] next_status;
	wire logic [`PBR_ST_W-1:0] next_irq_st;

	assign st_clr      = (wb_wr && sel_st) ? dat_i[`PBR_ST_W-1:0] : '0;
	assign next_status = (status & ~st_clr) | ev;

	// read clears only the bits that were returned
	assign irq_clr     = (wb_rd && sel_irq) ? dat_o[`PBR_ST_W-1:0] : '0;
	assign next_irq_st = (irq_st & ~irq_clr) | ev;

	assign irq_o = |(irq_st & irq_mask);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= wb_hit & ~ack_o;
			dat_o <= (wb_hit && !ack_o) ? rd_data : dat_o;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl <= `PBR_CTRL_RST;
		else if (wb_wr && sel_ctrl)
			ctrl <= dat_i[`PBR_CTRL_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask <= `PBR_ST_RST;
		else if (wb_wr && sel_mask)
			irq_mask <= dat_i[`PBR_ST_W-1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			status <= `PBR_ST_RST;
			irq_st <= `PBR_ST_RST;
			serr   <= 1'b0;
		end
		else
		begin
			status <= next_status;
			irq_st <= next_irq_st;
			serr   <= |rep_serr;
		end
	end

	a_pperr_delay: assert property (
		@(posedge clk_i) disable iff (rst_i)
		perr_req[0] |-> ##2 (!p_perr_n_o && p_perr_oe_o))
		else $error("primary perr not driven two cycles after error");

	a_pperr_cause: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(p_perr_oe_o && !p_perr_n_o) |->
			$past(err[0], 2) && $past(ctrl[`PBR_C_RESP], 2))
		else $error("primary perr driven without gated error");

	a_pdet_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		err[0] |=> status[`PBR_ST_DET])
		else $error("primary detected bit not set");

	a_sfwd_par: assert property (
		@(posedge clk_i) disable iff (rst_i)
		p_tgt_i.valid |=> s_fwd_o.valid
			&& (s_fwd_o.par == $past(p_tgt_i.par))
			&& (s_fwd_o.fwd == $past(err[0])))
		else $error("primary parity not reproduced downstream");

	a_sperr_delay: assert property (
		@(posedge clk_i) disable iff (rst_i)
		perr_req[1] |-> ##1 s_perr_n_o ##1 (!s_perr_n_o && s_perr_oe_o))
		else $error("secondary perr not driven two cycles after error");

	a_sdet_only: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(status[`PBR_ST_DET + 1]) |-> $past(err[1]))
		else $error("secondary detected bit set without secondary error");

	a_pfwd_par: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_tgt_i.valid |=> p_fwd_o.valid
			&& (p_fwd_o.par == $past(s_tgt_i.par)))
		else $error("secondary parity not reproduced upstream");

	a_sdpd_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(s_rep_i.valid && s_rep_i.perr && ctrl[`PBR_C_RESP + 1])
			|=> status[`PBR_ST_DPD + 1])
		else $error("secondary data parity detected not set");

	a_pwdis_serr: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(s_rep_i.valid && s_rep_i.posted && ctrl[`PBR_C_PWDIS]
			&& !rep_serr[0]) |=> !p_serr_oe_o)
		else $error("serr raised with posted write disable set");

	a_serr_fwd: assert property (
		@(posedge clk_i) disable iff (rst_i)
		p_serr_oe_o |-> $past(rep_serr != 2'b00)
			&& status[`PBR_ST_SERR])
		else $error("serr raised without unforwarded enabled cause");

	a_upserr_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(p_rep_i.valid && p_rep_i.perr && !p_rep_i.fwd
			&& ctrl[`PBR_C_SERREN] && both_resp) |=> p_serr_oe_o)
		else $error("upstream target perr did not raise serr");

	a_st_sticky: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(status[`PBR_ST_DET] && !(wb_wr && sel_st && dat_i[`PBR_ST_DET]))
			|=> status[`PBR_ST_DET])
		else $error("detected bit lost without write one");

	a_sperr_cause: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(s_perr_oe_o && !s_perr_n_o) |->
			$past(err[1], 2) && $past(ctrl[`PBR_C_RESP + 1], 2))
		else $error("secondary perr driven without gated error");

	a_sdet_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		err[1] |=> status[`PBR_ST_DET + 1])
		else $error("secondary detected bit not set");

	a_pdet_only: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(status[`PBR_ST_DET]) |-> $past(err[0]))
		else $error("primary detected bit set without primary error");

	a_pdpd_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(p_rep_i.valid && p_rep_i.perr && ctrl[`PBR_C_RESP])
			|=> status[`PBR_ST_DPD])
		else $error("primary data parity detected not set");

	a_sdpd_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(status[`PBR_ST_DPD + 1]) |->
			$past(s_rep_i.valid && s_rep_i.perr && ctrl[`PBR_C_RESP + 1]))
		else $error("secondary data parity detected set without cause");

	a_dnserr_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(s_rep_i.valid && s_rep_i.perr && !s_rep_i.fwd && ctrl[`PBR_C_SERREN]
			&& both_resp && !(s_rep_i.posted && ctrl[`PBR_C_PWDIS]))
			|=> p_serr_oe_o && status[`PBR_ST_SERR])
		else $error("downstream target perr did not raise serr");

	a_pfwd_flag: assert property (
		@(posedge clk_i) disable iff (rst_i)
		s_tgt_i.valid |=> (p_fwd_o.fwd == $past(err[1]))
			&& (p_fwd_o.data == $past(s_tgt_i.data)))
		else $error("secondary data or error flag not carried upstream");

	a_serr_nofwd: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(p_rep_i.valid && p_rep_i.fwd
			&& !(s_rep_i.valid && s_rep_i.perr && !s_rep_i.fwd))
			|=> !p_serr_oe_o)
		else $error("serr raised for forwarded upstream parity");

	a_st_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(wb_wr && sel_st && dat_i[`PBR_ST_DET] && !ev[`PBR_ST_DET])
			|=> !status[`PBR_ST_DET])
		else $error("detected bit not cleared by write one");

endmodule

`default_nettype wire

// file: verification/pbr_bus_model.sv
`timescale 1ns/100ps
`default_nettype none

module pbr_bus_model
	import pbr_pkg::*;
(
	// system
	input  wire logic   clk_i,
	// toward the bridge
	output var pbr_phase_t  phase_o,
	output var pbr_report_t rep_o
);
	initial
	begin
		phase_o = '0;
		rep_o = '0;
	end

	// one data phase, bad turns the parity round
	task automatic send(input pbr_kind_t k, input logic [31:0] d, input logic bad);
		@(posedge clk_i);
		phase_o <= {1'b1, k, d, 4'hf, ^{d, 4'hf} ^ bad};
		@(posedge clk_i);
		phase_o <= {1'b0, k, ~d, 4'h0, ~phase_o.par};
	endtask

	// one write phase delivered to us, perr as we saw it
	task automatic report(input logic perr, input logic fwd);
		@(posedge clk_i);
		rep_o <= {1'b1, 1'b1, perr, fwd};
		@(posedge clk_i);
		rep_o <= '0;
	endtask
endmodule

`default_nettype wire

// file: verification/pbr_bridge_perr_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbr_params.svh"

module pbr_bridge_perr_test;
	import pbr_pkg::*;
	logic        clk_i = 0;
	logic        rst_i = 1;
	logic        cyc = 0;
	logic        stb = 0;
	logic        we = 0;
	logic [3:0]  adr = 0;
	logic [31:0] wdat = 0;
	logic [31:0] rdat;
	logic        ack;
	pbr_phase_t  p_tgt;
	pbr_phase_t  s_tgt;
	pbr_report_t p_rep;
	pbr_report_t s_rep;
	pbr_fwd_t    p_fwd;
	pbr_fwd_t    s_fwd;
	logic        p_perr_n;
	logic        p_perr_oe;
	logic        p_serr_n;
	logic        p_serr_oe;
	logic        s_perr_n;
	logic        s_perr_oe;
	logic        irq;
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	pbr_bridge_perr u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(4'hf), .dat_o(rdat), .ack_o(ack),
		.p_tgt_i(p_tgt), .p_rep_i(p_rep), .p_fwd_o(p_fwd), .p_perr_n_o(p_perr_n),
		.p_perr_oe_o(p_perr_oe), .p_serr_n_o(p_serr_n), .p_serr_oe_o(p_serr_oe),
		.s_tgt_i(s_tgt), .s_rep_i(s_rep), .s_fwd_o(s_fwd), .s_perr_n_o(s_perr_n),
		.s_perr_oe_o(s_perr_oe), .irq_o(irq));
	pbr_bus_model u_pm (.clk_i(clk_i), .phase_o(p_tgt), .rep_o(p_rep));
	pbr_bus_model u_sm (.clk_i(clk_i), .phase_o(s_tgt), .rep_o(s_rep));

	always #2 clk_i = ~clk_i;

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 4000)
		begin
			fails++;
			tally_and_finish;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		cyc <= 0;
		stb <= 0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		wb(0, a, 32'h0);
		chk(rdat, exp);
	endtask

	task automatic sc_regs;
		rd(`PBR_ADR_CTRL, 32'h0);
		rd(`PBR_ADR_STATUS, 32'h0);
		wb(1, `PBR_ADR_CTRL, 32'hf);
		rd(`PBR_ADR_CTRL, 32'hf);
		wb(1, 4'h2, 32'hf);
		rd(4'h2, 32'h0);
	endtask

	task automatic sc_tgt(input logic sec, input logic resp);
		pbr_fwd_t f;
		wb(1, `PBR_ADR_CTRL, {30'h0, resp & sec, resp & ~sec});
		if (sec)
			u_sm.send(PBR_POSTED, 32'ha5c30f01, 1);
		else
			u_pm.send(PBR_POSTED, 32'ha5c30f01, 1);
		#1;
		f = sec ? p_fwd : s_fwd;
		chk(f.data, 32'ha5c30f01);
		chk({f.valid, f.fwd, f.par}, {2'b11, ~^{32'ha5c30f01, 4'hf}});
		chk(sec ? s_perr_oe : p_perr_oe, 0);
		@(posedge clk_i);
		#1;
		chk(sec ? {s_perr_oe, s_perr_n} : {p_perr_oe, p_perr_n}, resp ? 2'b10 : 2'b01);
		@(posedge clk_i);
		#1;
		chk(sec ? {s_perr_oe, s_perr_n} : {p_perr_oe, p_perr_n}, resp ? 2'b11 : 2'b01);
		rd(`PBR_ADR_STATUS, sec ? 32'h2 : 32'h1);
		wb(1, `PBR_ADR_STATUS, 32'h0);
		rd(`PBR_ADR_STATUS, sec ? 32'h2 : 32'h1);
		wb(1, `PBR_ADR_STATUS, 32'h1f);
		rd(`PBR_ADR_STATUS, 32'h0);
	endtask

	task automatic sc_rep(input logic sec, input logic [3:0] c, input logic fwd,
		input logic [4:0] st, input logic serr);
		wb(1, `PBR_ADR_CTRL, {28'h0, c});
		if (sec)
			u_sm.report(1, fwd);
		else
			u_pm.report(1, fwd);
		#1;
		chk(p_serr_oe, serr);
		chk(p_serr_n, 0);
		rd(`PBR_ADR_STATUS, {27'h0, st});
		wb(1, `PBR_ADR_STATUS, 32'h1f);
	endtask

	task automatic sc_irq;
		rd(`PBR_ADR_IRQ_ST, 32'h1f);
		wb(1, `PBR_ADR_CTRL, 32'h0);
		wb(1, `PBR_ADR_IRQ_MASK, 32'h1);
		rd(`PBR_ADR_IRQ_MASK, 32'h1);
		u_sm.send(PBR_POSTED, 32'h0, 1);
		repeat (3) @(posedge clk_i);
		chk(irq, 0);
		u_pm.send(PBR_POSTED, 32'h0, 1);
		repeat (3) @(posedge clk_i);
		chk(irq, 1);
		rd(`PBR_ADR_IRQ_ST, 32'h3);
		repeat (2) @(posedge clk_i);
		chk(irq, 0);
		rd(`PBR_ADR_IRQ_ST, 32'h0);
		wb(1, `PBR_ADR_STATUS, 32'h1f);
	endtask

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		sc_regs();
		sc_tgt(0, 1);
		sc_tgt(0, 0);
		sc_tgt(1, 1);
		sc_tgt(1, 0);
		sc_rep(1, 4'h7, 0, 5'h18, 1);
		sc_rep(1, 4'h7, 1, 5'h08, 0);
		sc_rep(1, 4'hf, 0, 5'h08, 0);
		sc_rep(1, 4'h3, 0, 5'h08, 0);
		sc_rep(1, 4'h5, 0, 5'h00, 0);
		sc_rep(0, 4'h7, 0, 5'h14, 1);
		sc_rep(0, 4'hf, 0, 5'h14, 1);
		sc_rep(0, 4'h6, 0, 5'h00, 0);
		sc_rep(0, 4'h7, 1, 5'h04, 0);
		sc_irq();
		tally_and_finish;
	end
endmodule

`default_nettype wire
